// ==== core/ranging_mode_trigger_control.sv ====
`timescale 1ns/1ps
`include "ranging_consts.svh"
module ranging_mode_trigger_control #(
  parameter logic [`RMT_CNT_W-1:0] TRIG_LATENCY =
    `RMT_CNT_W'(`RMT_TRIG_LATENCY_CYC),
  parameter logic [`RMT_CNT_W-1:0] PULSE_CYCLES =
    `RMT_CNT_W'(`RMT_PULSE_CYC)
) (
  input wire logic i_mclk,                      // System clock, 40 MHz.
  input wire logic i_rst_n,                     // Synchronous reset.
  input wire logic i_mode_triggered,            // 1 triggered, 0 free-run.
  input wire logic [`RMT_RATE_W-1:0] i_period,  // Sample period, cycles.
  input wire logic i_meas_done,                 // Measurement finished.
  output logic o_meas_start,                    // Start measurement pulse.
  output logic o_sample_ready,                  // New sample pulse.
  input wire logic i_evt,                       // Event pin level.
  output logic o_evt,                           // Event pin drive value.
  output logic o_evt_oe,                        // Event pin drive enable.
  input wire logic i_scl,                       // Bus clock pin level.
  output logic o_scl,                           // Bus clock drive value.
  output logic o_scl_oe,                        // High pulls clock low.
  input wire logic i_sda,                       // Bus data pin level.
  output logic o_sda,                           // Bus data drive value.
  output logic o_sda_oe,                        // High pulls data low.
  input wire logic i_app_addr_we,               // Load new app address.
  input wire logic [6:0] i_app_addr,            // New app address.
  output logic [6:0] o_app_addr,                // Current app address.
  output logic [7:0] o_rx_data,                 // Received byte.
  output logic o_rx_valid,                      // Received byte waiting.
  output logic o_rx_prog,                       // Byte is for program port.
  input wire logic i_rx_ready,                  // Receiver took the byte.
  input wire logic i_rx_accept,                 // 1 ack, 0 nack.
  output logic o_tx_req,                        // Next byte wanted.
  input wire logic i_tx_valid,                  // Transmit byte offered.
  input wire logic [7:0] i_tx_data              // Transmit byte.
);
  ranging_pkg::state_t st;
  ranging_pkg::state_t next_st;
  logic evt_rise;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic sda_now;
  logic addr_hit;

  function automatic logic rising(input logic [2:0] s);
    rising = s[1] & ~s[2];
  endfunction

  function automatic logic falling(input logic [2:0] s);
    falling = ~s[1] & s[2];
  endfunction

  always_comb begin
    evt_rise = rising(st.evt_sync);
    scl_rise = rising(st.pins.scl_sync);
    scl_fall = falling(st.pins.scl_sync);
    sda_now = st.pins.sda_sync[1];
    bus_start = st.pins.scl_sync[1] & falling(st.pins.sda_sync);
    bus_stop = st.pins.scl_sync[1] & rising(st.pins.sda_sync);
    addr_hit = (st.shreg[7:1] == `RMT_PROG_ADDR) ||
               (st.shreg[7:1] == st.app_addr);
  end

  always_comb begin
    next_st = st;
    next_st.meas_start = 1'b0;
    next_st.sample_ready = 1'b0;
    next_st.evt_sync = {st.evt_sync[1:0], i_evt};
    next_st.pins.scl_sync = {st.pins.scl_sync[1:0], i_scl};
    next_st.pins.sda_sync = {st.pins.sda_sync[1:0], i_sda};
    if (i_app_addr_we) begin
      next_st.app_addr = i_app_addr;
    end

    case (st.mstate)
      ranging_pkg::M_IDLE: begin
        if (!i_mode_triggered) begin
          if (st.rate_cnt >= i_period - `RMT_RATE_W'(1)) begin
            next_st.rate_cnt = '0;
            next_st.meas_start = 1'b1;
            next_st.mstate = ranging_pkg::M_MEASURE;
          end else begin
            next_st.rate_cnt = st.rate_cnt + `RMT_RATE_W'(1);
          end
        end else begin
          next_st.rate_cnt = '0;
          // Nothing starts here without a host edge on the line.
          if (evt_rise) begin
            next_st.cnt = '0;
            next_st.mstate = ranging_pkg::M_DELAY;
          end
        end
      end
      ranging_pkg::M_DELAY: begin
        // Latency is counted from the synchronised edge, so it is fixed.
        if (st.cnt >= TRIG_LATENCY - `RMT_CNT_W'(1)) begin
          next_st.meas_start = 1'b1;
          next_st.mstate = ranging_pkg::M_MEASURE;
        end else begin
          next_st.cnt = st.cnt + `RMT_CNT_W'(1);
        end
      end
      ranging_pkg::M_MEASURE: begin
        if (!i_mode_triggered) begin
          next_st.rate_cnt = st.rate_cnt + `RMT_RATE_W'(1);
        end
        if (i_meas_done) begin
          next_st.sample_ready = 1'b1;
          next_st.evt_drive = 1'b1;
          next_st.cnt = '0;
          next_st.mstate = ranging_pkg::M_PULSE;
        end
      end
      ranging_pkg::M_PULSE: begin
        if (!i_mode_triggered) begin
          next_st.rate_cnt = st.rate_cnt + `RMT_RATE_W'(1);
        end
        if (st.cnt >= PULSE_CYCLES - `RMT_CNT_W'(1)) begin
          next_st.evt_drive = 1'b0;
          // Our own pulse is still in the synchroniser; seeding it high
          // keeps it from reading back as a host trigger.
          next_st.evt_sync = 3'h7;
          next_st.mstate = ranging_pkg::M_IDLE;
        end else begin
          next_st.cnt = st.cnt + `RMT_CNT_W'(1);
        end
      end
      default: begin
        next_st.mstate = ranging_pkg::M_IDLE;
      end
    endcase

    case (st.istate)
      ranging_pkg::I_IDLE: begin
        next_st.scl_hold = 1'b0;
        next_st.sda_low = 1'b0;
      end
      ranging_pkg::I_SHIFT: begin
        if (scl_rise) begin
          next_st.shreg = {st.shreg[6:0], sda_now};
          next_st.bit_cnt = st.bit_cnt + 4'h1;
        end else if (scl_fall && st.bit_cnt == `RMT_BYTE_BITS) begin
          next_st.scl_hold = 1'b1;
          next_st.istate = ranging_pkg::I_HOLD;
        end
      end
      ranging_pkg::I_HOLD: begin
        if (st.is_addr) begin
          next_st.is_addr = 1'b0;
          next_st.is_read = st.shreg[0];
          next_st.sel_prog = (st.shreg[7:1] == `RMT_PROG_ADDR);
          next_st.ack_low = addr_hit;
          next_st.sda_low = addr_hit;
          next_st.scl_hold = 1'b0;
          next_st.istate = ranging_pkg::I_ACK;
        end else begin
          // Clock stays low until the receiver decides ack or nack.
          next_st.rx_valid = 1'b1;
          if (st.rx_valid && i_rx_ready) begin
            next_st.rx_valid = 1'b0;
            next_st.ack_low = i_rx_accept;
            next_st.sda_low = i_rx_accept;
            next_st.scl_hold = 1'b0;
            next_st.istate = ranging_pkg::I_ACK;
          end
        end
      end
      ranging_pkg::I_ACK: begin
        if (scl_fall) begin
          next_st.sda_low = 1'b0;
          next_st.bit_cnt = 4'h0;
          if (!st.ack_low) begin
            next_st.istate = ranging_pkg::I_IDLE;
          end else if (st.is_read) begin
            next_st.scl_hold = 1'b1;
            next_st.istate = ranging_pkg::I_LOAD;
          end else begin
            next_st.istate = ranging_pkg::I_SHIFT;
          end
        end
      end
      ranging_pkg::I_LOAD: begin
        if (i_tx_valid) begin
          next_st.shreg = i_tx_data;
          next_st.sda_low = ~i_tx_data[7];
          next_st.bit_cnt = 4'h0;
          next_st.scl_hold = 1'b0;
          next_st.istate = ranging_pkg::I_SEND;
        end
      end
      ranging_pkg::I_SEND: begin
        if (scl_fall) begin
          next_st.bit_cnt = st.bit_cnt + 4'h1;
          if (st.bit_cnt + 4'h1 == `RMT_BYTE_BITS) begin
            // Hold after the eighth bit while the next byte is fetched.
            next_st.sda_low = 1'b0;
            next_st.scl_hold = 1'b1;
            next_st.istate = ranging_pkg::I_HOLDTX;
          end else begin
            next_st.shreg = {st.shreg[6:0], 1'b0};
            next_st.sda_low = ~st.shreg[6];
          end
        end
      end
      ranging_pkg::I_HOLDTX: begin
        if (i_tx_valid) begin
          next_st.shreg = i_tx_data;
          next_st.scl_hold = 1'b0;
          next_st.ack_low = 1'b0;
          next_st.istate = ranging_pkg::I_MACK;
        end
      end
      ranging_pkg::I_MACK: begin
        if (scl_rise) begin
          next_st.ack_low = ~sda_now;
          if (sda_now) begin
            next_st.istate = ranging_pkg::I_IDLE;
          end
        end else if (scl_fall && st.ack_low) begin
          next_st.sda_low = ~st.shreg[7];
          next_st.bit_cnt = 4'h0;
          next_st.istate = ranging_pkg::I_SEND;
        end
      end
      default: begin
        next_st.istate = ranging_pkg::I_IDLE;
      end
    endcase

    // A start or stop aborts any byte in progress and frees both lines.
    if (bus_start) begin
      next_st.istate = ranging_pkg::I_SHIFT;
      next_st.is_addr = 1'b1;
      next_st.bit_cnt = 4'h0;
      next_st.rx_valid = 1'b0;
      next_st.scl_hold = 1'b0;
      next_st.sda_low = 1'b0;
    end else if (bus_stop) begin
      next_st.istate = ranging_pkg::I_IDLE;
      next_st.rx_valid = 1'b0;
      next_st.scl_hold = 1'b0;
      next_st.sda_low = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st <= '0;
      st.evt_sync <= 3'h0;
      st.pins.scl_sync <= 3'h7;
      st.pins.sda_sync <= 3'h7;
      st.app_addr <= `RMT_APP_ADDR_RST;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    o_meas_start = st.meas_start;
    o_sample_ready = st.sample_ready;
    o_evt = st.evt_drive;
    // Free-run owns the line; triggered mode shares it with the host.
    o_evt_oe = !i_mode_triggered || st.evt_drive;
    o_scl = 1'b0;
    o_scl_oe = st.scl_hold;
    o_sda = 1'b0;
    o_sda_oe = st.sda_low;
    o_app_addr = st.app_addr;
    o_rx_data = st.shreg;
    o_rx_valid = st.rx_valid;
    o_rx_prog = st.sel_prog;
    o_tx_req = (st.istate == ranging_pkg::I_LOAD) ||
               (st.istate == ranging_pkg::I_HOLDTX);
  end
endmodule

// ==== core/ranging_consts.svh ====
`ifndef RANGING_CONSTS_SVH
`define RANGING_CONSTS_SVH
`define RMT_CLK_PERIOD_NS 25
`define RMT_TRIG_LATENCY_NS 2000
`define RMT_TRIG_LATENCY_CYC \
  ((`RMT_TRIG_LATENCY_NS + `RMT_CLK_PERIOD_NS - 1) / `RMT_CLK_PERIOD_NS)
`define RMT_PULSE_NS 1000
`define RMT_PULSE_CYC \
  ((`RMT_PULSE_NS + `RMT_CLK_PERIOD_NS - 1) / `RMT_CLK_PERIOD_NS)
`define RMT_RATE_W 24
`define RMT_CNT_W 8
`define RMT_PROG_ADDR 7'h45
`define RMT_APP_ADDR_RST 7'h29
`define RMT_BYTE_BITS 4'h8
`endif

// ==== core/ranging_pkg.sv ====
`include "ranging_consts.svh"
package ranging_pkg;
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_DELAY = 2'b01,
    M_MEASURE = 2'b10,
    M_PULSE = 2'b11
  } meas_state_t;

  typedef enum logic [2:0] {
    I_IDLE = 3'b000,
    I_SHIFT = 3'b001,
    I_HOLD = 3'b010,
    I_ACK = 3'b011,
    I_LOAD = 3'b100,
    I_SEND = 3'b101,
    I_HOLDTX = 3'b110,
    I_MACK = 3'b111
  } bus_state_t;

  typedef struct packed {
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
  } bus_pins_t;

  typedef struct packed {
    meas_state_t mstate;
    logic [`RMT_RATE_W-1:0] rate_cnt;
    logic [`RMT_CNT_W-1:0] cnt;
    logic [2:0] evt_sync;
    logic evt_drive;
    logic meas_start;
    logic sample_ready;
    bus_state_t istate;
    bus_pins_t pins;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic is_addr;
    logic is_read;
    logic sel_prog;
    logic ack_low;
    logic scl_hold;
    logic sda_low;
    logic [6:0] app_addr;
    logic rx_valid;
  } state_t;
endpackage

// ==== bench/ranging_checker.sv ====
`timescale 1ns/1ps
`include "ranging_consts.svh"
module ranging_checker #(
  parameter logic [`RMT_CNT_W-1:0] TRIG_LATENCY = 8'h04,
  parameter logic [`RMT_CNT_W-1:0] PULSE_CYCLES = 8'h02
) (
  input wire logic i_mclk, // Clock.
  input wire logic i_rst_n, // Reset.
  input wire logic i_mode_triggered, // Mode.
  input wire logic [`RMT_RATE_W-1:0] i_period, // Period.
  input wire logic i_meas_done, // Done.
  input wire logic o_meas_start, // Start.
  input wire logic o_sample_ready, // Ready.
  input wire logic i_evt, // Pin level.
  input wire logic o_evt, // Pin drive.
  input wire logic o_evt_oe // Pin enable.
);
  logic prev_evt;
  logic seen;
  logic [7:0] since;
  logic [7:0] hi_cnt;
  logic [`RMT_RATE_W-1:0] gap;
  // Only host edges count, since the device's own pulse shows on the pin.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      prev_evt <= 1'b0;
      seen <= 1'b0;
      since <= 8'hFF;
      hi_cnt <= 8'h00;
      gap <= '0;
    end else begin
      prev_evt <= i_evt;
      if (i_evt && !prev_evt && !o_evt_oe) begin
        since <= 8'h00;
      end else if (since != 8'hFF) begin
        since <= since + 8'h01;
      end
      hi_cnt <= o_evt ? hi_cnt + 8'h01 : 8'h00;
      seen <= seen | o_meas_start;
      gap <= o_meas_start ? `RMT_RATE_W'(1) : gap + `RMT_RATE_W'(1);
    end
  end
  a_free_evt_out: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    !i_mode_triggered |-> o_evt_oe) else $error("event pin not driven");
  a_trig_shared: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    i_mode_triggered |-> o_evt_oe == o_evt) else $error("pin held");
  a_ready_cause: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    o_sample_ready |-> $past(i_meas_done) && o_evt) else $error("bad ready");
  a_evt_rise_ready: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    $rose(o_evt) |-> o_sample_ready) else $error("pulse without sample");
  a_evt_width: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    $fell(o_evt) |-> hi_cnt == PULSE_CYCLES) else $error("pulse width");
  a_start_single: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    o_meas_start |=> !o_meas_start) else $error("start too long");
  a_free_spacing: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    !i_mode_triggered && seen && o_meas_start |-> gap >= i_period)
    else $error("starts too close");
  a_trig_latency: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    i_mode_triggered && o_meas_start |->
      since >= TRIG_LATENCY && since <= TRIG_LATENCY + 8'h06)
    else $error("start not tied to trigger");
endmodule

// ==== bench/ranging_host_model.sv ====
`timescale 1ns/1ps
module ranging_host_model (
  input wire logic i_mclk, // Clock.
  input wire logic i_scl_w, // Bus clock wire.
  input wire logic i_sda_w, // Bus data wire.
  output logic o_evt_drv, // Drives event line high.
  output logic o_scl_low, // Pulls bus clock low.
  output logic o_sda_low // Pulls bus data low.
);
  logic [2:0] hold = 3'h0;
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end
  // A short pulse, then the line is let go and idles low.
  assign o_evt_drv = hold != 3'h0;
  always @(posedge i_mclk) begin
    if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end
  end
  // Each sensor has its own line, so the caller picks the moment.
  task automatic trigger();
    @(posedge i_mclk);
    hold <= 3'h4;
  endtask
  task automatic phase(input logic scl_low, input logic sda_low);
    o_scl_low <= scl_low;
    o_sda_low <= sda_low;
    repeat (8) @(posedge i_mclk);
  endtask
  // The slave may hold the clock low, so wait for the wire.
  task automatic scl_up(inout logic ok);
    int n;
    o_scl_low <= 1'b0;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (!i_scl_w && n < 300);
    ok = ok & i_scl_w;
    repeat (8) @(posedge i_mclk);
  endtask
  // One byte MSB first, then the slave's ack is read on the ninth clock.
  task automatic put(input logic [7:0] b, output logic ack,
                     inout logic ok);
    for (int i = 7; i >= 0; i--) begin
      phase(1'b1, !b[i]);
      scl_up(ok);
    end
    phase(1'b1, 1'b0);
    scl_up(ok);
    ack = !i_sda_w;
  endtask
  // Start, then the address byte with its read/write bit.
  task automatic start_frame(input logic [7:0] b, output logic ack,
                             output logic ok);
    ok = 1'b1;
    phase(1'b0, 1'b1);
    put(b, ack, ok);
  endtask
  // Data is left high on the ninth clock, a nack that ends the read.
  task automatic get(output logic [7:0] d, inout logic ok);
    for (int i = 7; i >= 0; i--) begin
      phase(1'b1, 1'b0);
      scl_up(ok);
      d[i] = i_sda_w;
    end
    phase(1'b1, 1'b0);
    scl_up(ok);
  endtask
  task automatic end_frame();
    phase(1'b1, 1'b1);
    phase(1'b0, 1'b1);
    phase(1'b0, 1'b0);
  endtask
endmodule

// ==== bench/ranging_mode_trigger_control_tb.sv ====
`timescale 1ns/1ps
`include "ranging_consts.svh"
module ranging_mode_trigger_control_tb;
  localparam logic [7:0] TL = 8'h04;
  localparam logic [7:0] PW = 8'h02;
  localparam logic [7:0] TX_BYTE = 8'hA5;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_mode_triggered = 1'b0;
  logic i_meas_done = 1'b0;
  logic i_app_addr_we = 1'b0;
  logic [`RMT_RATE_W-1:0] i_period = 24'h000014;
  logic [6:0] i_app_addr = 7'h00;
  logic [6:0] o_app_addr;
  logic o_meas_start, o_sample_ready, o_evt, o_evt_oe, o_scl_oe, o_sda_oe;
  logic o_scl, o_sda, o_rx_valid, o_rx_prog, o_tx_req, rx_prog;
  logic [7:0] o_rx_data, rx_byte;
  logic rx_accept = 1'b1;
  int tx_reqs = 0;
  int rx_seen = 0;
  logic host_evt, host_scl, host_sda;
  logic [2:0] eng = 3'h0;
  int starts = 0;
  int stretch = 0;
  int errors = 0;
  int checks = 0;
  // Event line has a pull-down, the bus wires have pull-ups.
  wire evt_w = host_evt | (o_evt_oe & o_evt);
  wire scl_w = !((o_scl_oe & !o_scl) | host_scl);
  wire sda_w = !((o_sda_oe & !o_sda) | host_sda);
  always #12.5 i_mclk = ~i_mclk;
  // Stand-in measurement engine that finishes soon after each start.
  always @(posedge i_mclk) begin
    eng <= {eng[1:0], o_meas_start};
    i_meas_done <= eng[2];
    starts <= starts + int'(o_meas_start);
    stretch <= stretch + int'(o_scl_oe);
    tx_reqs <= tx_reqs + int'(o_tx_req);
    if (o_rx_valid) begin
      rx_seen <= rx_seen + 1;
      rx_byte <= o_rx_data;
      rx_prog <= o_rx_prog;
    end
  end
  ranging_mode_trigger_control #(.TRIG_LATENCY(TL), .PULSE_CYCLES(PW)) u_dut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_mode_triggered(i_mode_triggered),
    .i_period(i_period), .i_meas_done(i_meas_done),
    .o_meas_start(o_meas_start), .o_sample_ready(o_sample_ready),
    .i_evt(evt_w), .o_evt(o_evt), .o_evt_oe(o_evt_oe), .i_scl(scl_w),
    .o_scl(o_scl), .o_scl_oe(o_scl_oe), .i_sda(sda_w), .o_sda(o_sda),
    .o_sda_oe(o_sda_oe), .i_app_addr_we(i_app_addr_we),
    .i_app_addr(i_app_addr), .o_app_addr(o_app_addr),
    .o_rx_data(o_rx_data), .o_rx_valid(o_rx_valid), .o_rx_prog(o_rx_prog),
    .i_rx_ready(1'b1), .i_rx_accept(rx_accept), .o_tx_req(o_tx_req),
    .i_tx_valid(1'b1), .i_tx_data(TX_BYTE));
  ranging_host_model u_host (.i_mclk(i_mclk), .i_scl_w(scl_w),
    .i_sda_w(sda_w), .o_evt_drv(host_evt), .o_scl_low(host_scl),
    .o_sda_low(host_sda));
  task automatic print_verdict();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic do_reset(input logic mode);
    @(posedge i_mclk);
    i_mode_triggered <= mode;
    i_rst_n <= 1'b0;
    repeat (10) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
  endtask
  task automatic wait_for(input logic sel, output int n);
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while ((sel ? o_sample_ready : o_meas_start) !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      errors++;
      print_verdict();
    end
  endtask
  task automatic t_free_run();
    int n;
    do_reset(1'b0);
    wait_for(1'b0, n);
    wait_for(1'b0, n);
    check(n, 32'(i_period));
    check(o_evt_oe, 1'b1);
    wait_for(1'b1, n);
    check(n, 32'h5);
    n = 0;
    while (o_evt === 1'b1 && n < 100) begin
      @(posedge i_mclk);
      n++;
    end
    check(n, 32'(PW));
  endtask
  task automatic t_trig();
    int s, l1, l2, n;
    do_reset(1'b1);
    s = starts;
    repeat (60) @(posedge i_mclk);
    check(starts - s, 0);
    u_host.trigger();
    wait_for(1'b0, l1);
    check(o_evt_oe, 1'b0);
    check(l1 >= TL + 1 && l1 <= TL + 6, 1'b1);
    wait_for(1'b1, n);
    check(o_evt_oe, 1'b1);
    repeat (10) @(posedge i_mclk);
    check(evt_w, 1'b0);
    u_host.trigger();
    wait_for(1'b0, l2);
    check(l2, l1);
  endtask
  task automatic bus_case(input logic [6:0] a, input logic exp);
    int s;
    logic ack, ok;
    s = stretch;
    u_host.start_frame({a, 1'b0}, ack, ok);
    u_host.end_frame();
    check(ack, exp);
    check(ok, 1'b1);
    if (exp) check(stretch > s, 1'b1);
  endtask
  task automatic t_bus();
    check(o_app_addr, 7'h29);
    bus_case(7'h45, 1'b1);
    bus_case(7'h29, 1'b1);
    bus_case(7'h33, 1'b0);
    i_app_addr <= 7'h33;
    i_app_addr_we <= 1'b1;
    @(posedge i_mclk);
    i_app_addr_we <= 1'b0;
    @(posedge i_mclk);
    check(o_app_addr, 7'h33);
    bus_case(7'h33, 1'b1);
    bus_case(7'h29, 1'b0);
  endtask
  task automatic t_rx();
    logic ack, ack2, ok;
    int s;
    s = rx_seen;
    u_host.start_frame({7'h45, 1'b0}, ack, ok);
    u_host.put(8'h3C, ack2, ok);
    u_host.end_frame();
    check(ack2, 1'b1);
    check(ok, 1'b1);
    check(rx_seen - s, 32'h1);
    check(rx_byte, 8'h3C);
    check(rx_prog, 1'b1);
    rx_accept <= 1'b0;
    u_host.start_frame({7'h33, 1'b0}, ack, ok);
    u_host.put(8'hC3, ack2, ok);
    u_host.end_frame();
    rx_accept <= 1'b1;
    check(ack, 1'b1);
    check(ack2, 1'b0);
    check(rx_byte, 8'hC3);
    check(rx_prog, 1'b0);
  endtask
  task automatic t_read();
    logic ack, ok;
    logic [7:0] d;
    int s, q;
    s = stretch;
    q = tx_reqs;
    u_host.start_frame({7'h33, 1'b1}, ack, ok);
    u_host.get(d, ok);
    u_host.end_frame();
    check(ack, 1'b1);
    check(d, TX_BYTE);
    check(ok, 1'b1);
    check(tx_reqs - q, 32'h2);
    check(stretch > s, 1'b1);
    check({o_scl, o_sda}, 2'h0);
  endtask
  initial begin
    t_free_run();
    t_trig();
    t_bus();
    t_rx();
    t_read();
    print_verdict();
  end
endmodule
bind ranging_mode_trigger_control ranging_checker #(
  .TRIG_LATENCY(TRIG_LATENCY), .PULSE_CYCLES(PULSE_CYCLES)) u_chk (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_mode_triggered(i_mode_triggered),
  .i_period(i_period), .i_meas_done(i_meas_done),
  .o_meas_start(o_meas_start), .o_sample_ready(o_sample_ready),
  .i_evt(i_evt), .o_evt(o_evt), .o_evt_oe(o_evt_oe));
